// ===== inc/iefc_pkg.sv
// Package for the interrupt enable and flag controller.
// Assumes an APB slave with 32-bit data; registers sit in the low byte of each word.
package iefc_pkg;
	localparam int unsigned ADDR_W = 8;

	localparam logic [7:0] OFF_CORE_CTRL = 8'h00;
	localparam logic [7:0] OFF_PIE_ONE   = 8'h04;
	localparam logic [7:0] OFF_PIE_TWO   = 8'h08;
	localparam logic [7:0] OFF_PIE_THREE = 8'h0C;
	localparam logic [7:0] OFF_PIR_ONE   = 8'h10;
	localparam logic [7:0] OFF_PIR_TWO   = 8'h14;
	localparam logic [7:0] OFF_PIR_THREE = 8'h18;
	localparam logic [7:0] OFF_CORE_CFG  = 8'h1C;
	localparam logic [7:0] OFF_EVT_STAT  = 8'h20;
	localparam logic [7:0] OFF_EVT_CLR   = 8'h24;
	localparam logic [7:0] OFF_EVT_EN    = 8'h28;

	// Core control register fields.
	localparam int unsigned BIT_GLB_EN = 7;
	localparam int unsigned BIT_PER_EN = 6;
	localparam int unsigned BIT_T0IE   = 5;
	localparam int unsigned BIT_EXTIE  = 4;
	localparam int unsigned BIT_PCIE   = 3;
	localparam int unsigned BIT_T0IF   = 2;
	localparam int unsigned BIT_EXTIF  = 1;
	localparam int unsigned BIT_PCIF   = 0;

	// Bits that software may write in the core control, enable and flag registers.
	localparam logic [7:0] MASK_CORE_W = 8'hFE;
	localparam logic [7:0] MASK_ONE    = 8'hC3;
	localparam logic [7:0] MASK_TWO    = 8'h24;
	localparam logic [7:0] MASK_THREE  = 8'h03;

	// Peripheral flag positions, shared with the matching enable positions.
	localparam int unsigned BIT_T1_GATE  = 7;
	localparam int unsigned BIT_ADC_DONE = 6;
	localparam int unsigned BIT_T2_MATCH = 1;
	localparam int unsigned BIT_T1_OVF   = 0;
	localparam int unsigned BIT_CMP_ONE  = 5;
	localparam int unsigned BIT_OSC      = 2;
	localparam int unsigned BIT_CELL_TWO = 1;
	localparam int unsigned BIT_CELL_ONE = 0;

	// Configuration register: edge select for the external pin.
	localparam int unsigned BIT_EDGE_SEL = 0;

	// Block event status bits.
	localparam int unsigned EVT_W        = 3;
	localparam int unsigned EVT_TAKEN    = 0;
	localparam int unsigned EVT_RETURN   = 1;
	localparam int unsigned EVT_EXT_EDGE = 2;

	localparam logic [7:0]  RST_BYTE = 8'h00;
	localparam logic [31:0] RD_ZERO  = 32'h0000_0000;
endpackage

// ===== design/iefc_ctrl.sv
// Interrupt enable and flag controller: core control register, three peripheral
// enable registers, peripheral flag capture and the combined request to the core.
// Assumes sources give one-cycle synchronous event pulses and the core pulses
// take and return strobes; all inputs are synchronous to clk_i.
//
// Contract
// - Global enable high passes enabled interrupts to core; low blocks all.
// - Peripheral-group enable must be high for any peripheral-register interrupt.
// - Timer0 overflow enable bit gates the Timer0 flag onto the request.
// - External pin enable bit gates the external pin flag onto the request.
// - Pin-change enable bit gates the pin-change summary flag onto the request.
// - Timer0 overflow sets its flag; it stays until software writes zero.
// - A qualifying external pin edge sets its flag; software writes zero.
// - Pin-change summary is read-only, high while any per-pin flag is set.
// - Flags set on their event regardless of any enable bit.
// - First enable register: gate bit7, ADC bit6, Timer2 bit1, Timer1 bit0.
// - Second enable register: comparator one bit5, oscillator bit2.
// - Third enable register: logic cell two bit1, logic cell one bit0.
// - Unimplemented bits ignore writes and read zero.
// - All enables and flags reset to zero.
// - Taking an interrupt clears global enable; core vectors to fixed address.
// - Return-from-interrupt sets global enable again; pending ones then serviced.
// - External flag sets on rising edge if edge select is one, else falling.
`timescale 1ns/1ns

module iefc_ctrl #(
	parameter int unsigned PIN_CHG_W = 12
) (
	input  wire logic                 clk_i,
	input  wire logic                 rst_i,
	input  wire logic                 psel_i,
	input  wire logic                 penable_i,
	input  wire logic                 pwrite_i,
	input  wire logic [7:0]           paddr_i,
	input  wire logic [31:0]          pwdata_i,
	input  wire logic [3:0]           pstrb_i,
	output logic      [31:0]          prdata_o,
	output logic                      pready_o,
	output logic                      pslverr_o,
	input  wire logic                 timer_zero_ovf_i,
	input  wire logic                 ext_pin_i,
	input  wire logic [PIN_CHG_W-1:0] per_pin_change_flags_i,
	input  wire logic                 timer_one_gate_evt_i,
	input  wire logic                 adc_done_evt_i,
	input  wire logic                 timer_two_match_evt_i,
	input  wire logic                 timer_one_ovf_evt_i,
	input  wire logic                 comparator_one_evt_i,
	input  wire logic                 num_osc_evt_i,
	input  wire logic                 logic_cell_two_evt_i,
	input  wire logic                 logic_cell_one_evt_i,
	input  wire logic                 irq_taken_i,
	input  wire logic                 return_from_isr_i,
	output logic                      core_irq_req_o,
	output logic                      wake_req_o,
	output logic                      block_irq_o
);

	// The summary OR and the port width are only meaningful for 1 to 32 pins.
	if (PIN_CHG_W < 1 || PIN_CHG_W > 32) begin : g_bad_width
		$error("PIN_CHG_W must be between 1 and 32");
	end

	typedef struct packed {
		logic [7:0]       core;
		logic [7:0]       pie_one;
		logic [7:0]       pie_two;
		logic [7:0]       pie_three;
		logic [7:0]       pir_one;
		logic [7:0]       pir_two;
		logic [7:0]       pir_three;
		logic [7:0]       cfg;
		logic [iefc_pkg::EVT_W-1:0] evt_stat;
		logic [iefc_pkg::EVT_W-1:0] evt_en;
		logic             pin_last;
		logic             pin_seen;
		logic [31:0]      rdata;
		logic             slverr;
	} iefc_state_s;

	iefc_state_s st_ff;
	iefc_state_s nxt_st;

	logic       wr_en;
	logic       rd_en;
	logic       hit;
	logic [7:0] wbyte;
	logic       pin_edge;
	logic       pin_chg_any;
	logic [7:0] core_view;
	logic       core_pend;
	logic       per_pend;
	logic [iefc_pkg::EVT_W-1:0] evt_set;

	// Zero-wait slave: every access completes in its first access cycle.
	assign wr_en = psel_i && penable_i && pwrite_i;
	assign rd_en = psel_i && penable_i && !pwrite_i;
	assign wbyte = pstrb_i[0] ? pwdata_i[7:0] : 8'h00;

	always_comb begin
		case (paddr_i)
			iefc_pkg::OFF_CORE_CTRL,
			iefc_pkg::OFF_PIE_ONE,
			iefc_pkg::OFF_PIE_TWO,
			iefc_pkg::OFF_PIE_THREE,
			iefc_pkg::OFF_PIR_ONE,
			iefc_pkg::OFF_PIR_TWO,
			iefc_pkg::OFF_PIR_THREE,
			iefc_pkg::OFF_CORE_CFG,
			iefc_pkg::OFF_EVT_STAT,
			iefc_pkg::OFF_EVT_CLR,
			iefc_pkg::OFF_EVT_EN: hit = 1'b1;
			default:              hit = 1'b0;
		endcase
	end

	assign pin_chg_any = |per_pin_change_flags_i;
	// The pin is compared against the previous sample only once one exists,
	// so the first cycle after reset never reports a false edge.
	assign pin_edge = st_ff.pin_seen && (st_ff.pin_last != ext_pin_i)
		&& (ext_pin_i == st_ff.cfg[iefc_pkg::BIT_EDGE_SEL]);

	always_comb begin
		core_view = st_ff.core;
		core_view[iefc_pkg::BIT_PCIF] = pin_chg_any;
	end

	assign core_pend = (core_view[iefc_pkg::BIT_T0IE] && core_view[iefc_pkg::BIT_T0IF])
		|| (core_view[iefc_pkg::BIT_EXTIE] && core_view[iefc_pkg::BIT_EXTIF])
		|| (core_view[iefc_pkg::BIT_PCIE] && core_view[iefc_pkg::BIT_PCIF]);
	assign per_pend = core_view[iefc_pkg::BIT_PER_EN]
		&& (|(st_ff.pie_one & st_ff.pir_one) || |(st_ff.pie_two & st_ff.pir_two)
		|| |(st_ff.pie_three & st_ff.pir_three));

	always_comb begin
		evt_set = '0;
		evt_set[iefc_pkg::EVT_TAKEN]    = irq_taken_i && st_ff.core[iefc_pkg::BIT_GLB_EN];
		evt_set[iefc_pkg::EVT_RETURN]   = return_from_isr_i;
		evt_set[iefc_pkg::EVT_EXT_EDGE] = pin_edge;
	end

	always_comb begin
		nxt_st = st_ff;
		nxt_st.pin_last = ext_pin_i;
		nxt_st.pin_seen = 1'b1;

		// Software writes go first so that hardware sets below win a same-cycle clear.
		if (wr_en) begin
			case (paddr_i)
				iefc_pkg::OFF_CORE_CTRL: begin
					nxt_st.core = wbyte & iefc_pkg::MASK_CORE_W;
				end
				iefc_pkg::OFF_PIE_ONE: begin
					nxt_st.pie_one = wbyte & iefc_pkg::MASK_ONE;
				end
				iefc_pkg::OFF_PIE_TWO: begin
					nxt_st.pie_two = wbyte & iefc_pkg::MASK_TWO;
				end
				iefc_pkg::OFF_PIE_THREE: begin
					nxt_st.pie_three = wbyte & iefc_pkg::MASK_THREE;
				end
				iefc_pkg::OFF_PIR_ONE: begin
					nxt_st.pir_one = wbyte & iefc_pkg::MASK_ONE;
				end
				iefc_pkg::OFF_PIR_TWO: begin
					nxt_st.pir_two = wbyte & iefc_pkg::MASK_TWO;
				end
				iefc_pkg::OFF_PIR_THREE: begin
					nxt_st.pir_three = wbyte & iefc_pkg::MASK_THREE;
				end
				iefc_pkg::OFF_CORE_CFG: begin
					nxt_st.cfg = {7'h00, wbyte[iefc_pkg::BIT_EDGE_SEL]};
				end
				iefc_pkg::OFF_EVT_CLR: begin
					nxt_st.evt_stat = st_ff.evt_stat & ~wbyte[iefc_pkg::EVT_W-1:0];
				end
				iefc_pkg::OFF_EVT_EN: begin
					nxt_st.evt_en = wbyte[iefc_pkg::EVT_W-1:0];
				end
				default: begin
					nxt_st.slverr = 1'b0;
				end
			endcase
		end

		// Flags set independently of every enable bit.
		if (timer_zero_ovf_i) begin
			nxt_st.core[iefc_pkg::BIT_T0IF] = 1'b1;
		end
		if (pin_edge) begin
			nxt_st.core[iefc_pkg::BIT_EXTIF] = 1'b1;
		end
		nxt_st.core[iefc_pkg::BIT_PCIF] = 1'b0;
		if (timer_one_gate_evt_i) begin
			nxt_st.pir_one[iefc_pkg::BIT_T1_GATE] = 1'b1;
		end
		if (adc_done_evt_i) begin
			nxt_st.pir_one[iefc_pkg::BIT_ADC_DONE] = 1'b1;
		end
		if (timer_two_match_evt_i) begin
			nxt_st.pir_one[iefc_pkg::BIT_T2_MATCH] = 1'b1;
		end
		if (timer_one_ovf_evt_i) begin
			nxt_st.pir_one[iefc_pkg::BIT_T1_OVF] = 1'b1;
		end
		if (comparator_one_evt_i) begin
			nxt_st.pir_two[iefc_pkg::BIT_CMP_ONE] = 1'b1;
		end
		if (num_osc_evt_i) begin
			nxt_st.pir_two[iefc_pkg::BIT_OSC] = 1'b1;
		end
		if (logic_cell_two_evt_i) begin
			nxt_st.pir_three[iefc_pkg::BIT_CELL_TWO] = 1'b1;
		end
		if (logic_cell_one_evt_i) begin
			nxt_st.pir_three[iefc_pkg::BIT_CELL_ONE] = 1'b1;
		end

		// The core's take strobe wins over a software write of global enable,
		// since the core must not re-enter the vector before the handler runs.
		if (irq_taken_i && st_ff.core[iefc_pkg::BIT_GLB_EN]) begin
			nxt_st.core[iefc_pkg::BIT_GLB_EN] = 1'b0;
		end else if (return_from_isr_i) begin
			nxt_st.core[iefc_pkg::BIT_GLB_EN] = 1'b1;
		end

		nxt_st.evt_stat = nxt_st.evt_stat | evt_set;

		nxt_st.slverr = 1'b0;
		nxt_st.rdata = iefc_pkg::RD_ZERO;
		if (psel_i && !penable_i) begin
			nxt_st.slverr = !hit;
			case (paddr_i)
				iefc_pkg::OFF_CORE_CTRL: nxt_st.rdata = {24'h00_0000, core_view};
				iefc_pkg::OFF_PIE_ONE:   nxt_st.rdata = {24'h00_0000, st_ff.pie_one};
				iefc_pkg::OFF_PIE_TWO:   nxt_st.rdata = {24'h00_0000, st_ff.pie_two};
				iefc_pkg::OFF_PIE_THREE: nxt_st.rdata = {24'h00_0000, st_ff.pie_three};
				iefc_pkg::OFF_PIR_ONE:   nxt_st.rdata = {24'h00_0000, st_ff.pir_one};
				iefc_pkg::OFF_PIR_TWO:   nxt_st.rdata = {24'h00_0000, st_ff.pir_two};
				iefc_pkg::OFF_PIR_THREE: nxt_st.rdata = {24'h00_0000, st_ff.pir_three};
				iefc_pkg::OFF_CORE_CFG:  nxt_st.rdata = {24'h00_0000, st_ff.cfg};
				iefc_pkg::OFF_EVT_STAT:  nxt_st.rdata = {29'h0000_0000, st_ff.evt_stat};
				iefc_pkg::OFF_EVT_EN:    nxt_st.rdata = {29'h0000_0000, st_ff.evt_en};
				default:                 nxt_st.rdata = iefc_pkg::RD_ZERO;
			endcase
		end else if (psel_i && penable_i) begin
			nxt_st.slverr = st_ff.slverr;
			nxt_st.rdata = st_ff.rdata;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			st_ff <= '0;
		end else begin
			st_ff <= nxt_st;
		end
	end

	assign core_irq_req_o = core_view[iefc_pkg::BIT_GLB_EN] && (core_pend || per_pend);
	// Wake-up ignores global enable, so a sleeping core resumes on any enabled source.
	assign wake_req_o = core_pend || per_pend;
	assign block_irq_o = |(st_ff.evt_stat & st_ff.evt_en);
	assign pready_o = 1'b1;
	assign pslverr_o = psel_i && penable_i && st_ff.slverr;
	assign prdata_o = (rd_en && !st_ff.slverr) ? st_ff.rdata : iefc_pkg::RD_ZERO;

endmodule

// ===== verification/iefc_monitor.sv
// Port checker for the interrupt enable and flag controller.
// Assumes one clock domain with a synchronous active-high reset.
`timescale 1ns/1ns
module iefc_monitor #(
	parameter int unsigned PIN_CHG_W = 12
) (
	input wire logic                 clk_i,
	input wire logic                 rst_i,
	input wire logic                 psel_i,
	input wire logic                 penable_i,
	input wire logic                 pwrite_i,
	input wire logic [7:0]           paddr_i,
	input wire logic [31:0]          pwdata_i,
	input wire logic [31:0]          prdata_o,
	input wire logic                 pslverr_o,
	input wire logic [PIN_CHG_W-1:0] per_pin_change_flags_i,
	input wire logic                 irq_taken_i,
	input wire logic                 return_from_isr_i,
	input wire logic                 core_irq_req_o,
	input wire logic                 wake_req_o,
	input wire logic                 block_irq_o
);
	default clocking @(posedge clk_i); endclocking
	default disable iff (rst_i);
	logic rd_acc;
	assign rd_acc = psel_i && penable_i && !pwrite_i;
	sequence s_take;
		irq_taken_i && core_irq_req_o && !return_from_isr_i && !(psel_i && pwrite_i);
	endsequence
	sequence s_ret;
		return_from_isr_i && wake_req_o && !irq_taken_i && !(psel_i && pwrite_i);
	endsequence
	a_req_needs_wake: assert property (core_irq_req_o |-> wake_req_o)
		else $error("request without an enabled pending source");
	a_take_clears: assert property (s_take |=> !core_irq_req_o)
		else $error("request still high after take");
	a_return_sets: assert property (
		s_ret ##1 $stable(per_pin_change_flags_i) |-> core_irq_req_o)
		else $error("request low after return with a pending source");
	a_glb_write_off: assert property (
		psel_i && penable_i && pwrite_i && paddr_i == iefc_pkg::OFF_CORE_CTRL
		&& !pwdata_i[iefc_pkg::BIT_GLB_EN] && !return_from_isr_i |=> !core_irq_req_o)
		else $error("request with global off");
	a_unmapped_err: assert property (psel_i && penable_i && paddr_i[1:0] == 2'h0 |->
		pslverr_o == (paddr_i > iefc_pkg::OFF_EVT_EN)) else $error("error response wrong");
	a_upper_zero: assert property (prdata_o[31:8] == 24'h00_0000)
		else $error("read data above the byte not zero");
	a_summary_live: assert property (rd_acc && paddr_i == iefc_pkg::OFF_CORE_CTRL |->
		prdata_o[0] == |$past(per_pin_change_flags_i)) else $error("summary flag wrong");
	a_third_unused: assert property (rd_acc && paddr_i == iefc_pkg::OFF_PIE_THREE |->
		prdata_o[7:2] == 6'h00) else $error("unused enable bits not zero");
	a_reset_quiet: assert property (disable iff (1'h0) rst_i |=> !wake_req_o && !block_irq_o)
		else $error("request after reset");
endmodule
bind iefc_ctrl iefc_monitor #(.PIN_CHG_W(PIN_CHG_W)) iefc_monitor_i (.clk_i(clk_i),
	.rst_i(rst_i), .psel_i(psel_i), .penable_i(penable_i), .pwrite_i(pwrite_i),
	.paddr_i(paddr_i), .pwdata_i(pwdata_i), .prdata_o(prdata_o), .pslverr_o(pslverr_o),
	.per_pin_change_flags_i(per_pin_change_flags_i), .irq_taken_i(irq_taken_i),
	.return_from_isr_i(return_from_isr_i), .core_irq_req_o(core_irq_req_o),
	.wake_req_o(wake_req_o), .block_irq_o(block_irq_o));

// ===== verification/iefc_src_model.sv
// Event sources and core model: one-cycle event pulses on command, and a take strobe.
// Assumes commands from the bench are synchronous to clk_i.
`timescale 1ns/1ns
module iefc_src_model (
	input  wire logic       clk_i,
	input  wire logic [3:0] fire_i,
	input  wire logic       take_en_i,
	input  wire logic [3:0] lat_i,
	input  wire logic       core_irq_req_i,
	output logic      [8:0] evt_o,
	output logic            taken_o
);
	logic [3:0] wait_cnt = 4'h0;
	initial evt_o = 9'h000;
	initial taken_o = 1'h0;
	// The take waits lat_i cycles of steady request, so a slow core can be modelled.
	always @(posedge clk_i) begin
		evt_o <= (fire_i == 4'h0) ? 9'h000 : 9'h001 << (fire_i - 4'h1);
		wait_cnt <= (core_irq_req_i && take_en_i && !taken_o) ? wait_cnt + 4'h1 : 4'h0;
		taken_o <= (wait_cnt == lat_i) && core_irq_req_i && take_en_i;
	end
endmodule

// ===== verification/test_interrupt_enable_and_flag_control.sv
// Self-checking bench for the interrupt enable and flag controller.
// Assumes the register map and zero-wait APB answer of the design package.
`timescale 1ns/1ns
module test_interrupt_enable_and_flag_control;
	logic        clk_i = 1'h0;
	logic        rst_i = 1'h1;
	logic        psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
	logic [7:0]  paddr = 8'h00;
	logic [31:0] pwdata = 32'h0000_0000, prdata, rdat;
	logic        pready, pslverr, rerr, req, wake, blk, taken;
	logic        ext_pin = 1'h0, ret = 1'h0, take_en = 1'h0;
	logic [11:0] pins = 12'h000;
	logic [3:0]  fire = 4'h0, lat = 4'h3;
	logic [8:0]  evt;
	int          n_errors = 0, n_compared = 0;
	iefc_ctrl iefc_ctrl_i (.clk_i(clk_i), .rst_i(rst_i), .psel_i(psel), .penable_i(penable),
		.pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata), .pstrb_i(4'h1),
		.prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr),
		.timer_zero_ovf_i(evt[8]), .ext_pin_i(ext_pin), .per_pin_change_flags_i(pins),
		.timer_one_gate_evt_i(evt[0]), .adc_done_evt_i(evt[1]), .timer_two_match_evt_i(evt[2]),
		.timer_one_ovf_evt_i(evt[3]), .comparator_one_evt_i(evt[4]), .num_osc_evt_i(evt[5]),
		.logic_cell_two_evt_i(evt[6]), .logic_cell_one_evt_i(evt[7]), .irq_taken_i(taken),
		.return_from_isr_i(ret), .core_irq_req_o(req), .wake_req_o(wake), .block_irq_o(blk));
	iefc_src_model iefc_src_model_i (.clk_i(clk_i), .fire_i(fire), .take_en_i(take_en),
		.lat_i(lat), .core_irq_req_i(req), .evt_o(evt), .taken_o(taken));
	initial forever #2 clk_i = ~clk_i;
	task automatic summarize;
		$display("compared %0d, mismatches %0d", n_compared, n_errors);
		if (n_errors == 0 && n_compared > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_compared++;
		if (got !== exp) begin
			n_errors++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic apb(input logic [7:0] a, input logic wr, input logic [31:0] d);
		@(posedge clk_i);
		{psel, penable, paddr, pwrite, pwdata} <= {2'h2, a, wr, d};
		@(posedge clk_i);
		penable <= 1'h1;
		do @(posedge clk_i); while (pready !== 1'h1);
		rdat = prdata;
		rerr = pslverr;
		{psel, penable} <= 2'h0;
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		apb(a, 1'h1, d);
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] e);
		apb(a, 1'h0, 32'h0000_0000);
		chk(rdat, e);
	endtask
	task automatic drv(input logic [3:0] k, input logic p);
		fire <= k;
		ext_pin <= p;
		@(posedge clk_i);
		fire <= 4'h0;
		repeat (2) @(posedge clk_i);
	endtask
	task automatic t_regs;
		logic [7:0] off [4] = '{8'h00, 8'h04, 8'h08, 8'h0C};
		logic [7:0] msk [4] = '{8'hFE, 8'hC3, 8'h24, 8'h03};
		for (int i = 0; i < 4; i++) begin
			rd(off[i], 32'h0000_0000);
			wr(off[i], 32'hFFFF_FFFF);
			rd(off[i], {24'h00_0000, msk[i]});
			wr(off[i], 32'h0000_0000);
		end
		apb(8'h40, 1'h0, 32'h0000_0000);
		chk({rdat[30:0], rerr}, 32'h0000_0001);
		$display("registers test ended");
	endtask
	task automatic t_timer;
		drv(4'h9, 1'h0);
		rd(8'h00, 32'h0000_0004);
		chk(32'(req), 32'h0000_0000);
		wr(8'h00, 32'h0000_00A4);
		@(posedge clk_i);
		chk(32'(req), 32'h0000_0001);
		wr(8'h00, 32'h0000_0024);
		@(posedge clk_i);
		chk(32'({wake, req}), 32'h0000_0002);
		wr(8'h00, 32'h0000_0020);
		rd(8'h00, 32'h0000_0020);
		wr(8'h00, 32'h0000_0000);
		$display("timer test ended");
	endtask
	task automatic t_periph;
		logic [7:0] bv [8] = '{8'h80, 8'h40, 8'h02, 8'h01, 8'h20, 8'h04, 8'h02, 8'h01};
		logic [7:0] grp;
		for (int i = 0; i < 8; i++) begin
			grp = 8'h04 + 8'((i / 4) + (i / 6)) * 8'h04;
			wr(8'h00, 32'h0000_0080);
			wr(grp, {24'h00_0000, bv[i]});
			drv(4'(i + 1), 1'h0);
			rd(grp + 8'h0C, {24'h00_0000, bv[i]});
			chk(32'(req), 32'h0000_0000);
			wr(8'h00, 32'h0000_00C0);
			@(posedge clk_i);
			chk(32'(req), 32'h0000_0001);
			wr(grp + 8'h0C, 32'h0000_0000);
			@(posedge clk_i);
			chk(32'(req), 32'h0000_0000);
			wr(grp, 32'h0000_0000);
		end
		wr(8'h00, 32'h0000_0000);
		$display("peripheral test ended");
	endtask
	task automatic t_ext;
		logic [1:0] ev [4] = '{2'h1, 2'h0, 2'h1, 2'h0};
		logic [1:0] fl [4] = '{2'h2, 2'h0, 2'h0, 2'h2};
		for (int i = 0; i < 4; i++) begin
			if (i == 2) wr(8'h1C, 32'h0000_0000);
			if (i == 0) wr(8'h1C, 32'h0000_0001);
			drv(4'h0, ev[i][0]);
			rd(8'h00, {30'h0000_0000, fl[i]});
			wr(8'h00, 32'h0000_0000);
		end
		wr(8'h00, 32'h0000_0090);
		@(posedge clk_i);
		chk(32'(req), 32'h0000_0000);
		drv(4'h0, 1'h1);
		drv(4'h0, 1'h0);
		chk(32'(req), 32'h0000_0001);
		wr(8'h00, 32'h0000_0082);
		@(posedge clk_i);
		chk(32'(req), 32'h0000_0000);
		wr(8'h00, 32'h0000_0000);
		$display("external pin test ended");
	endtask
	task automatic t_pins;
		pins <= 12'h800;
		rd(8'h00, 32'h0000_0001);
		wr(8'h00, 32'h0000_0088);
		@(posedge clk_i);
		chk(32'(req), 32'h0000_0001);
		pins <= 12'h000;
		repeat (2) @(posedge clk_i);
		chk(32'(req), 32'h0000_0000);
		rd(8'h00, 32'h0000_0088);
		wr(8'h00, 32'h0000_0000);
		$display("pin change test ended");
	endtask
	task automatic t_take;
		wr(8'h24, 32'h0000_0007);
		wr(8'h28, 32'h0000_0007);
		wr(8'h00, 32'h0000_00A0);
		take_en <= 1'h1;
		drv(4'h9, 1'h0);
		for (int i = 0; i < 20 && taken !== 1'h1; i++) @(posedge clk_i);
		take_en <= 1'h0;
		repeat (2) @(posedge clk_i);
		chk({blk, req}, 32'h0000_0002);
		rd(8'h00, 32'h0000_0024);
		rd(8'h20, 32'h0000_0001);
		wr(8'h28, 32'h0000_0000);
		@(posedge clk_i);
		chk(32'(blk), 32'h0000_0000);
		wr(8'h24, 32'h0000_0007);
		ret <= 1'h1;
		@(posedge clk_i);
		ret <= 1'h0;
		@(posedge clk_i);
		chk(32'(req), 32'h0000_0001);
		rd(8'h00, 32'h0000_00A4);
		wr(8'h00, 32'h0000_0000);
		wr(8'h24, 32'h0000_0007);
		$display("take and return test ended");
	endtask
	initial begin
		repeat (6) @(posedge clk_i);
		rst_i <= 1'h0;
		t_regs;
		t_timer;
		t_periph;
		t_ext;
		t_pins;
		t_take;
		summarize;
	end
	initial begin
		repeat (20000) @(posedge clk_i);
		n_errors++;
		summarize;
	end
endmodule
